/* hbi_defs.svh */
// constants for the host bus interface block
`ifndef HBI_DEFS_SVH
`define HBI_DEFS_SVH
// bus setup register reset value and field positions
`define HBI_SETUP_RST 8'h00
`define HBI_B_SHIFT 0
`define HBI_B_ACK_LO 1
`define HBI_B_ACK_HI 2
`define HBI_B_SWAP_SENSE 6
`define HBI_B_SWAP_EN 7
// timing: clock period and least length of each master bus phase
`define HBI_CLK_NS 10
`define HBI_PHASE_NS 30
`define HBI_PHASE_CYC ((`HBI_PHASE_NS + `HBI_CLK_NS - 1) / `HBI_CLK_NS)
`endif

/* hbi_pkg.sv */
// types shared by the host bus interface block
package hbi_pkg;
  // section reached by a slave access; 2'b11 never occurs
  typedef enum logic [1:0] {
    HBI_SEC_DMA = 2'b00,
    HBI_SEC_CHB = 2'b01,
    HBI_SEC_CHA = 2'b10
  } hbi_sect_e;
  // acknowledge type held in setup bits 2:1
  typedef enum logic [1:0] {
    HBI_ACK_STATUS = 2'b00,
    HBI_ACK_SINGLE = 2'b01,
    HBI_ACK_RSVD = 2'b10,
    HBI_ACK_DOUBLE = 2'b11
  } hbi_ack_e;
  // master sequencer states
  typedef enum logic [2:0] {
    HBI_M_IDLE = 3'b000,
    HBI_M_REQ = 3'b001,
    HBI_M_HIADR = 3'b010,
    HBI_M_LOADR = 3'b011,
    HBI_M_DATA = 3'b100,
    HBI_M_REL = 3'b101
  } hbi_mst_e;
  // one slave access handed to the inner sections
  typedef struct packed {
    hbi_sect_e sect;
    logic [4:0] index;
    logic write;
    logic [7:0] wdata;
  } hbi_acc_s;
  // one dma byte transfer requested by the dma section
  typedef struct packed {
    logic [31:0] addr;
    logic [1:0] chan;
    logic read;
    logic [7:0] wdata;
  } hbi_dma_s;
endpackage

/* hbi_vec_ack.sv */
// interrupt acknowledge handler: decides when the vector is driven
`timescale 1ns/10ps
module hbi_vec_ack import hbi_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // acknowledge type and synchronised acknowledge level
  input wire hbi_ack_e ack_type,
  input wire logic ack_act,
  input wire logic [7:0] vector,
  // vector drive
  output logic vec_oe,
  output logic [15:0] vec_data
);
  logic seen_reg, seen_next; // first pulse of a double pair seen
  logic prev_reg, prev_next; // last acknowledge level
  logic oe_reg, oe_next;
  logic [15:0] data_reg, data_next;
  logic fall;

  // next values of the acknowledge tracker
  always_comb begin
    fall = prev_reg & ~ack_act;
    prev_next = ack_act;
    seen_next = seen_reg;
    data_next = {vector, vector}; // both halves always driven together
    if (ack_type != HBI_ACK_DOUBLE) begin
      seen_next = 1'b0;
    end else if (fall) begin
      // end of first pulse arms, end of second disarms
      seen_next = ~seen_reg;
    end
    unique case (ack_type)
      HBI_ACK_STATUS: oe_next = ack_act;
      HBI_ACK_SINGLE: oe_next = ack_act;
      HBI_ACK_DOUBLE: oe_next = ack_act & seen_reg;
      HBI_ACK_RSVD: oe_next = 1'b0; // undefined type, stay off the bus
    endcase
  end

  // tracker registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_reg <= 1'b0;
      prev_reg <= 1'b0;
      oe_reg <= 1'b0;
      data_reg <= 16'h0000;
    end else if (ce) begin
      seen_reg <= seen_next;
      prev_reg <= prev_next;
      oe_reg <= oe_next;
      data_reg <= data_next;
    end
  end

  assign vec_oe = oe_reg;
  assign vec_data = data_reg;

  AST_DBL_FIRST_QUIET: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && ack_type == HBI_ACK_DOUBLE && ack_act && !seen_reg) |=> !vec_oe)
    else $error("vector driven on first double acknowledge pulse");
  AST_SINGLE_DRIVE: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && ack_type == HBI_ACK_SINGLE && ack_act) |=> vec_oe && vec_data[7:0] == $past(vector))
    else $error("vector not driven on single acknowledge pulse");
  COV_DBL_SECOND: cover property (@(posedge clk) disable iff (!rst_n)
    ack_type == HBI_ACK_DOUBLE && vec_oe);
endmodule // hbi_vec_ack

/* hbi_host_bus.sv */
// host bus interface: slave decode, bus setup and dma bus master pins
// Functional notes
// - select pins driven while dma master
// - section and channel pins route access
// - reset default is left shift decode
// - strobe before setup write selects multiplexed
// - strobe counts even with chip select off
// - dma moves single bytes only
// - double acknowledge: vector on second pulse
// - single acknowledge: vector on pulse
// - first write setup; channel high means wait
// - value 86H: swap with sense clear (upper byte on even address), double acknowledge
// - upper address with high address strobe
// - address strobe driven while dma master
// - strobe pins driven only as master
// - setup bits 2:1 choose acknowledge type
// - setup bit 0 chooses dma shift
// - setup bits 7:6 byte swap on reads
`timescale 1ns/10ps
`include "hbi_defs.svh"
module hbi_host_bus import hbi_pkg::*; (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // host pins in (asynchronous)
  input wire logic cs_n,
  input wire logic section_select_pin_i,
  input wire logic channel_select_pin_i,
  input wire logic addr_strobe_n_i,
  input wire logic wr_n_i,
  input wire logic rd_n_i,
  input wire logic vector_ack_input_n,
  input wire logic bus_ack_n,
  input wire logic [15:0] ad_i,
  // host pins out
  output logic [15:0] ad_o,
  output logic ad_oe,
  output logic section_select_pin_o,
  output logic channel_select_pin_o,
  output logic sel_oe,
  output logic addr_strobe_n_o,
  output logic high_addr_strobe_n,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic rw_n_o,
  output logic data_strobe_pin_n_o,
  output logic strobe_oe,
  output logic bus_req_n,
  output logic wait_mode,
  // inner sections
  input wire logic [7:0] rd_data,
  input wire logic [7:0] vector,
  input wire logic dma_req,
  input wire hbi_dma_s dma_in,
  output hbi_acc_s acc,
  output logic acc_valid,
  output logic dma_done,
  output logic [7:0] dma_rdata,
  // setup state
  output logic configured,
  output logic mux_mode,
  output logic [7:0] bus_setup_register
);
  localparam int NSYNC = 24;
  localparam logic [3:0] PHASE_LAST = 4'(`HBI_PHASE_CYC - 1);

  // two-stage synchronisers for every pin input
  logic [NSYNC-1:0] pin_raw, pin_s1, pin_s2, pin_d;
  assign pin_raw = {cs_n, section_select_pin_i, channel_select_pin_i, addr_strobe_n_i,
                    wr_n_i, rd_n_i, vector_ack_input_n, bus_ack_n, ad_i};
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      // first stage feeds only the second
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          pin_s1[gi] <= 1'b1;
          pin_s2[gi] <= 1'b1;
          pin_d[gi] <= 1'b1;
        end else if (ce) begin
          pin_s1[gi] <= pin_raw[gi];
          pin_s2[gi] <= pin_s1[gi];
          pin_d[gi] <= pin_s2[gi];
        end
      end
    end
  endgenerate

  // synchronised pin views
  logic cs_act, sec_s, ch_s, as_fall, as_rise, wr_evt, rd_evt, rd_act, ack_act, bus_ack;
  logic [15:0] ad_s;
  assign cs_act = ~pin_s2[23];
  assign sec_s = pin_s2[22];
  assign ch_s = pin_s2[21];
  assign as_fall = ~pin_s2[20] & pin_d[20];
  assign as_rise = pin_s2[20] & ~pin_d[20];
  assign wr_evt = ~pin_s2[19] & pin_d[19];
  assign rd_evt = ~pin_s2[18] & pin_d[18];
  assign rd_act = ~pin_s2[18];
  assign ack_act = ~pin_s2[17];
  assign bus_ack = ~pin_s2[16];
  assign ad_s = pin_s2[15:0];

  // setup and slave state
  logic configured_reg, configured_next;
  logic mux_reg, mux_next;
  logic wait_reg, wait_next;
  logic [7:0] setup_reg, setup_next;
  logic [5:0] adr_reg, adr_next; // multiplexed address latched on strobe end
  hbi_acc_s acc_reg, acc_next;
  logic acc_valid_reg, acc_valid_next;
  logic slave_oe_reg, slave_oe_next;
  logic slave_mode;
  hbi_sect_e sect;
  logic [4:0] index;
  hbi_ack_e ack_type;

  // master state
  hbi_mst_e mst_reg, mst_next;
  logic [3:0] cnt_reg, cnt_next;
  hbi_dma_s dma_reg, dma_next;
  logic [7:0] rdata_reg, rdata_next;
  logic done_reg, done_next;
  logic breq_n_reg, breq_n_next; // bus request pin level, active low
  logic mst_drv, upper_lane;

  // pin output registers
  logic [15:0] ad_reg, ad_next;
  logic ad_oe_reg, ad_oe_next;
  logic [6:0] pins_reg, pins_next; // sec, ch, as, uas, rd, wr, rw
  logic ds_reg, ds_next;
  logic drv_reg, drv_next;

  // vector acknowledge
  logic vec_oe;
  logic [15:0] vec_data;

  // 86H gives swap and double acknowledge
  assign ack_type = hbi_ack_e'(setup_reg[`HBI_B_ACK_HI:`HBI_B_ACK_LO]);
  assign slave_mode = (mst_reg == HBI_M_IDLE) || (mst_reg == HBI_M_REQ);

  hbi_vec_ack i_hbi_vec_ack (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .ack_type(ack_type),
    .ack_act(ack_act),
    .vector(vector),
    .vec_oe(vec_oe),
    .vec_data(vec_data)
  );

  // slave decode: section, channel and register index
  always_comb begin
    if (!sec_s) begin
      sect = HBI_SEC_DMA;
    end else if (ch_s) begin
      sect = HBI_SEC_CHA;
    end else begin
      sect = HBI_SEC_CHB;
    end
    index = adr_reg[5:1];
    if (mux_reg && sect == HBI_SEC_DMA && setup_reg[`HBI_B_SHIFT]) begin
      index = adr_reg[4:0];
    end
    // without multiplexing no address travels on the data lines
    if (!mux_reg) begin
      index = 5'h00;
    end
  end

  // next values of setup and slave state
  always_comb begin
    configured_next = configured_reg;
    mux_next = mux_reg;
    wait_next = wait_reg;
    setup_next = setup_reg;
    adr_next = adr_reg;
    acc_next = acc_reg;
    acc_valid_next = 1'b0;
    slave_oe_next = cs_act & rd_act & slave_mode & configured_reg;
    if (as_fall && !configured_reg) begin
      mux_next = 1'b1;
    end
    if (as_rise && mux_reg) begin
      adr_next = ad_s[5:0];
    end
    if (cs_act && slave_mode && wr_evt) begin
      if (!configured_reg) begin
        // first write, channel pin picks wait
        configured_next = 1'b1;
        setup_next = ad_s[7:0];
        wait_next = ch_s;
      end else begin
        acc_valid_next = 1'b1;
        acc_next = '{sect: sect, index: index, write: 1'b1, wdata: ad_s[7:0]};
      end
    end else if (cs_act && slave_mode && rd_evt && configured_reg) begin
      acc_valid_next = 1'b1;
      acc_next = '{sect: sect, index: index, write: 1'b0, wdata: 8'h00};
    end
  end

  // dma byte lane choice for reads into the device
  always_comb begin
    upper_lane = setup_reg[`HBI_B_SWAP_EN] & ~(setup_reg[`HBI_B_SWAP_SENSE] ^ dma_reg.addr[0]);
  end

  // next values of the master sequencer
  always_comb begin
    mst_next = mst_reg;
    cnt_next = cnt_reg;
    dma_next = dma_reg;
    rdata_next = rdata_reg;
    done_next = 1'b0;
    breq_n_next = breq_n_reg;
    unique case (mst_reg)
      HBI_M_IDLE: begin
        // no transfer before the bus is configured; a grant left over from
        // the last transfer must be seen gone, else it would start us unasked
        if (dma_req && configured_reg && !bus_ack) begin
          mst_next = HBI_M_REQ;
          dma_next = dma_in;
          breq_n_next = 1'b0;
        end
      end
      HBI_M_REQ: begin
        // pins stay quiet until the grant arrives
        if (bus_ack) begin
          mst_next = HBI_M_HIADR;
          cnt_next = PHASE_LAST;
        end
      end
      HBI_M_HIADR: begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_reg == 4'h0) begin
          mst_next = HBI_M_LOADR;
          cnt_next = PHASE_LAST;
        end
      end
      HBI_M_LOADR: begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_reg == 4'h0) begin
          mst_next = HBI_M_DATA;
          cnt_next = PHASE_LAST;
        end
      end
      HBI_M_DATA: begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_reg == 4'h0) begin
          mst_next = HBI_M_REL;
          if (dma_reg.read) begin
            rdata_next = upper_lane ? ad_s[15:8] : ad_s[7:0];
          end
        end
      end
      HBI_M_REL: begin
        mst_next = HBI_M_IDLE;
        breq_n_next = 1'b1;
        done_next = 1'b1;
      end
      default: begin
        mst_next = HBI_M_IDLE;
        breq_n_next = 1'b1;
      end
    endcase
  end

  // next pin levels, from the state being entered
  always_comb begin
    mst_drv = (mst_next == HBI_M_HIADR) || (mst_next == HBI_M_LOADR) ||
              (mst_next == HBI_M_DATA);
    drv_next = mst_drv;
    // idle levels are inactive high; channel code shows on select pins
    pins_next = {dma_next.chan[0], dma_next.chan[1], 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
    ds_next = 1'b1;
    ad_next = 16'h0000;
    ad_oe_next = 1'b0;
    unique case (mst_next)
      HBI_M_HIADR: begin
        pins_next[3] = 1'b0;
        ad_next = dma_next.addr[31:16];
        ad_oe_next = 1'b1;
      end
      HBI_M_LOADR: begin
        pins_next[4] = 1'b0;
        ad_next = dma_next.addr[15:0];
        ad_oe_next = 1'b1;
      end
      HBI_M_DATA: begin
        ds_next = 1'b0;
        pins_next[2] = ~dma_next.read;
        pins_next[1] = dma_next.read;
        pins_next[0] = dma_next.read;
        ad_next = {8'h00, dma_next.wdata};
        ad_oe_next = ~dma_next.read;
      end
      default: begin
        // slave: vector first, then register read data
        if (vec_oe) begin
          ad_next = vec_data;
          ad_oe_next = 1'b1;
        end else if (slave_oe_reg) begin
          ad_next = {rd_data, rd_data};
          ad_oe_next = 1'b1;
        end
      end
    endcase
  end

  // all state registers but the synchronisers; ce low freezes everything
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      configured_reg <= 1'b0;
      mux_reg <= 1'b0;
      wait_reg <= 1'b0;
      setup_reg <= `HBI_SETUP_RST;
      adr_reg <= 6'h00;
      acc_reg <= '0;
      acc_valid_reg <= 1'b0;
      slave_oe_reg <= 1'b0;
      mst_reg <= HBI_M_IDLE;
      cnt_reg <= 4'h0;
      dma_reg <= '0;
      rdata_reg <= 8'h00;
      done_reg <= 1'b0;
      breq_n_reg <= 1'b1;
      ad_reg <= 16'h0000;
      ad_oe_reg <= 1'b0;
      pins_reg <= 7'h7F;
      ds_reg <= 1'b1;
      drv_reg <= 1'b0;
    end else if (ce) begin
      configured_reg <= configured_next;
      mux_reg <= mux_next;
      wait_reg <= wait_next;
      setup_reg <= setup_next;
      adr_reg <= adr_next;
      acc_reg <= acc_next;
      acc_valid_reg <= acc_valid_next;
      slave_oe_reg <= slave_oe_next;
      mst_reg <= mst_next;
      cnt_reg <= cnt_next;
      dma_reg <= dma_next;
      rdata_reg <= rdata_next;
      done_reg <= done_next;
      breq_n_reg <= breq_n_next;
      ad_reg <= ad_next;
      ad_oe_reg <= ad_oe_next;
      pins_reg <= pins_next;
      ds_reg <= ds_next;
      drv_reg <= drv_next;
    end
  end

  // outputs straight from registers
  assign ad_o = ad_reg;
  assign ad_oe = ad_oe_reg;
  assign {section_select_pin_o, channel_select_pin_o} = pins_reg[6:5];
  assign addr_strobe_n_o = pins_reg[4];
  assign high_addr_strobe_n = pins_reg[3];
  assign {rd_n_o, wr_n_o, rw_n_o} = pins_reg[2:0];
  assign data_strobe_pin_n_o = ds_reg;
  assign sel_oe = drv_reg;
  assign strobe_oe = drv_reg;
  assign bus_req_n = breq_n_reg;
  assign wait_mode = wait_reg;
  assign acc = acc_reg;
  assign acc_valid = acc_valid_reg;
  assign dma_done = done_reg;
  assign dma_rdata = rdata_reg;
  assign configured = configured_reg;
  assign mux_mode = mux_reg;
  assign bus_setup_register = setup_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_FIRST_WR_SETUP: assert property (
    (ce && cs_act && slave_mode && wr_evt && !configured_reg) |=>
      configured_reg && wait_reg == $past(ch_s) && !acc_valid_reg)
    else $error("first write did not load the bus setup");
  AST_LATER_WR_ACC: assert property (
    (ce && cs_act && slave_mode && wr_evt && configured_reg) |=>
      acc_valid_reg && acc_reg.write && $stable(setup_reg))
    else $error("later write touched bus setup");
  AST_MUX_DETECT: assert property (
    (ce && as_fall && !configured_reg) |=> mux_reg)
    else $error("address strobe before setup missed");
  AST_SETUP_86: assert property (
    (configured_reg && setup_reg == 8'h86) |->
      upper_lane == ~dma_reg.addr[0] && ack_type == HBI_ACK_DOUBLE)
    else $error("setup 86H decoded wrongly");
  AST_LEFT_SHIFT: assert property (
    (ce && cs_act && slave_mode && wr_evt && configured_reg && mux_reg &&
     !setup_reg[`HBI_B_SHIFT]) |=> acc_reg.index == $past(adr_reg[5:1]))
    else $error("left shift index wrong");
  AST_DMA_RIGHT: assert property (
    (ce && cs_act && slave_mode && wr_evt && configured_reg && mux_reg && !sec_s &&
     setup_reg[`HBI_B_SHIFT]) |=> acc_reg.index == $past(adr_reg[4:0]))
    else $error("dma right shift index wrong");
  AST_ROUTE_CHA: assert property (
    (ce && cs_act && slave_mode && wr_evt && configured_reg && sec_s && ch_s) |=>
      acc_reg.sect == HBI_SEC_CHA)
    else $error("channel A routing wrong");
  AST_MASTER_DRIVE: assert property (
    (mst_reg inside {HBI_M_HIADR, HBI_M_LOADR, HBI_M_DATA}) |-> sel_oe && strobe_oe)
    else $error("pins not driven while master");
  AST_SLAVE_QUIET: assert property (
    (mst_reg == HBI_M_IDLE || mst_reg == HBI_M_REQ) |-> !strobe_oe && !sel_oe)
    else $error("pins driven while slave");
  AST_UPPER_ADDR: assert property (
    (mst_reg == HBI_M_HIADR) |-> !high_addr_strobe_n && ad_o == dma_reg.addr[31:16])
    else $error("upper address phase wrong");
  AST_BYTE_ONLY: assert property (
    (mst_reg == HBI_M_DATA && !dma_reg.read) |-> ad_o[15:8] == 8'h00 && ad_oe)
    else $error("dma write not a single byte");

  COV_SETUP: cover property (configured_reg && mux_reg);
  COV_DMA_READ: cover property (done_reg && dma_reg.read);
  COV_SLAVE_RD: cover property (acc_valid_reg && !acc_reg.write);
endmodule // hbi_host_bus

/* hbi_host_model.sv */
// host side model: bus grant, dma read data and upper byte strobe glue
`timescale 1ns/10ps
module hbi_host_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // device master pins
  input wire logic bus_req_n,
  input wire logic strobe_oe,
  input wire logic addr_strobe_n,
  input wire logic rd_n,
  input wire logic [15:0] ad_o,
  // test controls
  input wire logic [3:0] grant_wait,
  input wire logic [15:0] rd_word,
  // host answers
  output logic bus_ack_n,
  output logic host_en,
  output logic [15:0] host_ad,
  output logic upper_byte_strobe_n,
  output logic ube_oe
);
  logic [3:0] cnt_reg; // grant delay count
  logic a0_reg; // latched low address bit
  // grant after a chosen delay, so both prompt and slow arbiters are seen
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 4'h0;
      bus_ack_n <= 1'b1;
      a0_reg <= 1'b0;
    end else begin
      if (strobe_oe && !addr_strobe_n) a0_reg <= ad_o[0];
      // withdraw at once when request drops
      if (bus_req_n) begin
        cnt_reg <= 4'h0;
        bus_ack_n <= 1'b1;
      end else if (cnt_reg >= grant_wait) begin
        bus_ack_n <= 1'b0;
      end else begin
        cnt_reg <= cnt_reg + 4'h1;
      end
    end
  end
  // memory drives the bus only while the read strobe is low
  assign host_en = strobe_oe && !rd_n;
  assign host_ad = rd_word;
  assign upper_byte_strobe_n = ~a0_reg;
  assign ube_oe = strobe_oe;
endmodule // hbi_host_model

/* tb_hbi_host_bus.sv */
// self-checking bench for the host bus interface block
`timescale 1ns/10ps
module tb_hbi_host_bus import hbi_pkg::*;;
  logic clk, rst_n, ce, cs_n, section_select_pin_i, channel_select_pin_i;
  logic addr_strobe_n_i, wr_n_i, rd_n_i, vector_ack_input_n, bus_ack_n, dma_req;
  logic [15:0] ad_i, ad_o, tb_ad, host_ad, rd_word;
  logic ad_oe, section_select_pin_o, channel_select_pin_o, sel_oe, addr_strobe_n_o;
  logic high_addr_strobe_n, rd_n_o, wr_n_o, rw_n_o, data_strobe_pin_n_o, strobe_oe;
  logic bus_req_n, wait_mode, acc_valid, dma_done, configured, mux_mode, host_en;
  logic [7:0] rd_data, vector, dma_rdata, bus_setup_register, d;
  logic [3:0] grant_wait;
  logic [5:0] adr;
  logic [4:0] ix;
  logic sec, ch;
  hbi_dma_s dma_in;
  hbi_acc_s acc, acc_got;
  int miscompares, n_tests, st;
  bit got_acc, mux;
  logic [16:0] drv_got; // bus drive seen at the end of an access
  logic [7:0] modes [4] = '{8'h86, 8'h02, 8'hC1, 8'h04}; // double, single, status, reserved
  // wire level: device first, then memory, else host side
  assign ad_i = ad_oe ? ad_o : (host_en ? host_ad : tb_ad);
  hbi_host_bus i_hbi_host_bus (.clk, .rst_n, .ce, .cs_n, .section_select_pin_i,
    .channel_select_pin_i, .addr_strobe_n_i, .wr_n_i, .rd_n_i, .vector_ack_input_n,
    .bus_ack_n, .ad_i, .ad_o, .ad_oe, .section_select_pin_o, .channel_select_pin_o,
    .sel_oe, .addr_strobe_n_o, .high_addr_strobe_n, .rd_n_o, .wr_n_o, .rw_n_o,
    .data_strobe_pin_n_o, .strobe_oe, .bus_req_n, .wait_mode, .rd_data, .vector,
    .dma_req, .dma_in, .acc, .acc_valid, .dma_done, .dma_rdata, .configured,
    .mux_mode, .bus_setup_register);
  hbi_host_model i_hbi_host_model (.clk, .rst_n, .bus_req_n, .strobe_oe,
    .addr_strobe_n(addr_strobe_n_o), .rd_n(rd_n_o), .ad_o, .grant_wait, .rd_word,
    .bus_ack_n, .host_en, .host_ad, .upper_byte_strobe_n(), .ube_oe());
  // free running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // host write or read; strobes held long enough for the synchronisers
  task automatic hwr(input logic s, input logic c, input logic [5:0] a, input logic [7:0] v,
                     input logic w);
    got_acc = 0;
    section_select_pin_i <= s;
    channel_select_pin_i <= c;
    tb_ad <= {10'h000, a};
    // address strobe with chip select still off
    if (mux) begin
      addr_strobe_n_i <= 1'b0;
      cyc(3);
      addr_strobe_n_i <= 1'b1;
    end
    cyc(3);
    tb_ad <= {8'h00, v};
    cs_n <= 1'b0;
    if (w) begin
      wr_n_i <= 1'b0;
    end else begin
      rd_n_i <= 1'b0;
    end
    repeat (6) begin
      @(negedge clk);
      drv_got = {ad_oe, ad_o};
      if (acc_valid === 1'b1) begin
        got_acc = 1;
        acc_got = acc;
      end
    end
    @(posedge clk);
    wr_n_i <= 1'b1;
    rd_n_i <= 1'b1;
    cs_n <= 1'b1;
    cyc(4);
  endtask
  // one acknowledge pulse, vector drive expected or not
  task automatic ack(input logic drv);
    vector <= 8'($urandom);
    vector_ack_input_n <= 1'b0;
    cyc(5);
    @(negedge clk);
    chk(ad_oe, drv);
    if (drv) chk(ad_o, {vector, vector});
    @(posedge clk);
    vector_ack_input_n <= 1'b1;
    cyc(5);
  endtask
  // one dma byte transfer, pins checked every master cycle
  task automatic dma(input logic rd);
    logic [31:0] a;
    logic [1:0] c2;
    logic [7:0] wd;
    int oe_n;
    bit done;
    a = $urandom;
    c2 = 2'($urandom);
    wd = 8'($urandom);
    oe_n = 0;
    done = 0;
    rd_word <= 16'($urandom);
    grant_wait <= 4'($urandom_range(7, 0));
    dma_in <= '{addr: a, chan: c2, read: rd, wdata: wd};
    // hold the request until the bus request pin answers
    dma_req <= 1'b1;
    for (int k = 0; k < 20 && bus_req_n !== 1'b0; k++) begin
      @(negedge clk);
    end
    @(posedge clk);
    dma_req <= 1'b0;
    for (int k = 0; k < 80 && !done; k++) begin
      @(negedge clk);
      if (strobe_oe === 1'b1) begin
        oe_n++;
        chk({sel_oe, bus_ack_n, channel_select_pin_o, section_select_pin_o}, {2'b10, c2});
        if (high_addr_strobe_n === 1'b0) chk(ad_o, a[31:16]);
        if (addr_strobe_n_o === 1'b0) chk(ad_o, a[15:0]);
        if (wr_n_o === 1'b0) chk({ad_oe, ad_o}, {1'b1, 8'h00, wd});
        if (data_strobe_pin_n_o === 1'b0) chk({rd_n_o, wr_n_o, rw_n_o}, {~rd, rd, rd});
      end
      if (dma_done === 1'b1) done = 1;
    end
    chk({done, oe_n[7:0]}, {1'b1, 8'h09});
    // lane choice: swap off means low byte
    if (rd) chk(dma_rdata, (!st[7] || st[6] != a[0]) ? rd_word[7:0] : rd_word[15:8]);
    @(posedge clk);
  endtask
  // main sequence: one reset and setup per acknowledge mode
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    cs_n = 1'b1;
    section_select_pin_i = 1'b0;
    channel_select_pin_i = 1'b0;
    addr_strobe_n_i = 1'b1;
    wr_n_i = 1'b1;
    rd_n_i = 1'b1;
    vector_ack_input_n = 1'b1;
    dma_req = 1'b0;
    tb_ad = 16'h0000;
    rd_word = 16'h0000;
    grant_wait = 4'h0;
    vector = 8'h00;
    dma_in = '0;
    miscompares = 0;
    n_tests = 0;
    void'($urandom(61621));
    rd_data = 8'($urandom);
    cyc(6);
    foreach (modes[m]) begin
      st = modes[m];
      mux = (m != 1);
      // mid-run reset for later modes
      if (m != 0) begin
        rst_n <= 1'b0;
        cyc(2);
      end
      rst_n <= 1'b1;
      cyc(2);
      @(negedge clk);
      chk({configured, mux_mode, bus_setup_register,
           strobe_oe, sel_oe, ad_oe, bus_req_n}, 14'h0001);
      dma_req <= 1'b1;
      cyc(6);
      @(negedge clk);
      chk(bus_req_n, 1'b1);
      @(posedge clk);
      dma_req <= 1'b0;
      hwr(1'b1, m == 0, 6'h00, modes[m], 1'b1);
      @(negedge clk);
      chk({got_acc, configured, mux_mode, wait_mode, bus_setup_register},
          {1'b0, 1'b1, mux, m == 0, modes[m]});
      @(posedge clk);
      // status and single drive at once; double drives on its second pulse only, reserved stays off
      ack(!st[2]);
      if (st[2:1] == 2'b11) ack(1'b1);
      for (int k = 0; k < 3; k++) begin
        sec = (k != 0);
        ch = (k == 1);
        adr = 6'($urandom);
        d = 8'($urandom);
        hwr(sec, ch, adr, d, 1'b1);
        ix = !mux ? 5'h00 : (!sec && st[0]) ? adr[4:0] : adr[5:1];
        chk({got_acc, acc_got.sect, acc_got.index, acc_got.write, acc_got.wdata},
            {1'b1, sec & ch, sec & ~ch, ix, 1'b1, d});
        // same address read back: access pulse and both lanes driven
        rd_data <= 8'($urandom);
        hwr(sec, ch, adr, d, 1'b0);
        chk({got_acc, acc_got.sect, acc_got.index, acc_got.write, drv_got},
            {1'b1, sec & ch, sec & ~ch, ix, 1'b0, 1'b1, rd_data, rd_data});
      end
      dma(1'b1);
      dma(1'b0);
    end
    give_verdict;
  end
  // watchdog well past the expected run length
  initial begin
    cyc(20000);
    miscompares++;
    give_verdict;
  end
endmodule // tb_hbi_host_bus
